// ==== rtl/fdcc_pkg.sv ====
// Behaviour
// - Interrupt on result phase, seek end, transfer
// - Sense-interrupt clears interrupt, reports cause
// - Cause codes: poll 0/11, seek 1/00, 1/01
// - Side bit reads zero in sense result
// - Drive stays busy until interrupt sensed
// - Drive status answers without execution phase
// - Head unload time from code, rate scaled
// - Step spacing from step-rate code, rate scaled
// - Head load wait before transfer starts
// - DMA bypass bit selects non-DMA transfers
// - DMA request, or ready bit plus interrupt
// - Reset defaults: no seek, FIFO off, polling
// - Auto-seek before read or write when enabled
// - FIFO off means one byte per request
// - One poll interrupt after reset, head unloaded
// - Trigger level sets burst of 1..16 bytes
// - Precompensation from start track upward
// - Version returns one fixed byte
// - Relative seek steps count, direction bit
// - Only one relative seek active at once
// - Outward past track zero sets fault flag
// - Cylinder becomes old plus or minus count, by direction bit, mod 256, unless an outward seek stops at track zero
// - Seek direction from present versus target
package fdcc_pkg;

   // Register byte offsets
   localparam logic [7:0] OFS_CMD     = 8'h00;
   localparam logic [7:0] OFS_SPECIFY = 8'h04;
   localparam logic [7:0] OFS_CONFIG  = 8'h08;
   localparam logic [7:0] OFS_SEEKARG = 8'h0C;
   localparam logic [7:0] OFS_STATUS  = 8'h10;
   localparam logic [7:0] OFS_RESULT  = 8'h14;
   localparam logic [7:0] OFS_DATA    = 8'h18;
   localparam logic [7:0] OFS_RATE    = 8'h1C;
   localparam logic [7:0] OFS_CYL     = 8'h20;

   // Command codes in CMD[3:0]
   localparam logic [3:0] OP_SEEK      = 4'h1;
   localparam logic [3:0] OP_REL_SEEK  = 4'h2;
   localparam logic [3:0] OP_RECAL     = 4'h3;
   localparam logic [3:0] OP_SENSE_INT = 4'h4;
   localparam logic [3:0] OP_SENSE_DRV = 4'h5;
   localparam logic [3:0] OP_VERSION   = 4'h6;
   localparam logic [3:0] OP_XFER      = 4'h7;

   // Reset values
   localparam logic [3:0] RST_SRT     = 4'h0;
   localparam logic [3:0] RST_HUT     = 4'h0;
   localparam logic [6:0] RST_HLT     = 7'h00;
   localparam logic       RST_EIS     = 1'b0;
   localparam logic       RST_FIFO_OFF_BIT   = 1'b1;
   localparam logic       RST_POLLDIS = 1'b0;
   localparam logic [3:0] RST_THR     = 4'h0;
   localparam logic [7:0] RST_PRECOMP_START_TRACK  = 8'h00;
   localparam logic [2:0] RST_RATE    = 3'h2;

   // Primary status byte codes
   localparam logic [1:0] IC_NORMAL   = 2'h0;
   localparam logic [1:0] IC_ABNORMAL = 2'h1;
   localparam logic [1:0] IC_INVALID  = 2'h2;
   localparam logic [1:0] IC_POLL     = 2'h3;

   // Data rate codes
   localparam logic [2:0] RATE_2M   = 3'h0;
   localparam logic [2:0] RATE_1M   = 3'h1;
   localparam logic [2:0] RATE_500K = 3'h2;
   localparam logic [2:0] RATE_300K = 3'h3;
   localparam logic [2:0] RATE_250K = 3'h4;

   // Timing: one unit is 0.25 ms at 2 Mbps
   localparam int          CLK_PERIOD_NS = 25;
   localparam int          UNIT_2M_NS    = 250000;
   localparam int          UNIT_2M_CYC   = UNIT_2M_NS / CLK_PERIOD_NS;
   localparam logic [4:0]  SRT_BASE      = 5'h10;
   localparam logic [8:0]  TIME_CODE0    = 9'h100;
   localparam logic [6:0]  RECAL_MAX     = 7'h4F;

   typedef enum logic [2:0] {
      FDCC_P_IDLE,
      FDCC_P_SEEK,
      FDCC_P_HLOAD,
      FDCC_P_HWAIT,
      FDCC_P_XFER
   } fdcc_phase_t;

   typedef enum logic [1:0] {
      FDCC_M_SEEK,
      FDCC_M_REL,
      FDCC_M_RECAL,
      FDCC_M_IMPL
   } fdcc_seek_t;

endpackage

// ==== rtl/fdcc_timer.sv ====
`timescale 1ns/1ps
`default_nettype none
module fdcc_timer #(
   parameter int UW = 9,
   parameter int CW = 32
) (
   // Clock and reset
   input  wire logic          clk,
   input  wire logic          rst_n,
   // Control
   input  wire logic          start,
   input  wire logic          stop,
   input  wire logic [UW-1:0] units,
   input  wire logic [CW-1:0] unit_cyc,
   // Status
   output logic               busy,
   output logic               done
);

   typedef struct packed {
      logic [UW-1:0] left;
      logic [CW-1:0] cyc;
      logic          busy;
      logic          done;
   } fdcc_tmr_t;

   fdcc_tmr_t r;
   fdcc_tmr_t n;

   always_comb begin
      n = r;
      n.done = 1'b0;
      if (stop) begin
         n.busy = 1'b0;
      end else if (start) begin
         n.busy = 1'b1;
         n.left = units;
         n.cyc  = unit_cyc;
      end else if (r.busy) begin
         if (r.cyc > 1) begin
            n.cyc = r.cyc - 1'b1;
         end else if (r.left > 1) begin
            n.left = r.left - 1'b1;
            n.cyc  = unit_cyc;
         end else begin
            n.busy = 1'b0;
            n.done = 1'b1;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         r <= '0;
      end else begin
         r <= n;
      end
   end

   assign busy = r.busy;
   assign done = r.done;

endmodule // fdcc_timer
`default_nettype wire

// ==== rtl/fdcc_top.sv ====
// The register addresses and the APB register port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module fdcc_top #(
   parameter int          UNIT_CYC   = fdcc_pkg::UNIT_2M_CYC,
   parameter logic [7:0]  VERSION_ID = 8'h5A  // Arbitrary value
) (
   // Clock and reset
   input  wire logic        CLK,
   input  wire logic        RST_N,
   // APB slave
   input  wire logic        PSEL,
   input  wire logic        PENABLE,
   input  wire logic        PWRITE,
   input  wire logic [7:0]  PADDR,
   input  wire logic [31:0] PWDATA,
   output logic [31:0]      PRDATA,
   output logic             PREADY,
   output logic             PSLVERR,
   // Drive sense pins
   input  wire logic        TRK0,
   input  wire logic        WPROT,
   input  wire logic        READY_IN,
   input  wire logic        TWO_SIDE,
   // DMA acknowledge
   input  wire logic        XFER_ACK,
   // Host and drive outputs
   output logic             INT,
   output logic             DRQ,
   output logic             STEP,
   output logic             DIR,
   output logic             HEAD_LOAD,
   output logic             PRECOMP
);

   typedef struct packed {
      logic [31:0]          prdata;
      logic                 pready;
      logic                 pslverr;
      logic [3:0]           step_rate_time;
      logic [3:0]           head_unload_time;
      logic [6:0]           head_load_time;
      logic                 nd;
      logic                 auto_seek_enable;
      logic                 fifo_off_bit;
      logic                 poll_dis;
      logic [3:0]           thr;
      logic [7:0]           precomp_start_track;
      logic [7:0]           target;
      logic [7:0]           relcnt;
      logic                 reldir;
      logic [2:0]           rate;
      logic [7:0]           present_cylinder;
      logic [7:0]           st0;
      logic                 intr;
      logic                 busy;
      logic                 poll_done;
      logic [7:0]           res0;
      logic [7:0]           res1;
      logic                 res_valid;
      fdcc_pkg::fdcc_phase_t phase;
      fdcc_pkg::fdcc_seek_t  smode;
      logic [7:0]           steps_left;
      logic [6:0]           recal_cnt;
      logic                 step;
      logic                 dir;
      logic                 head;
      logic                 drq;
      logic                 host_transfer_ready_bit;
      logic                 precomp;
      logic                 wr_dir;
      logic [7:0]           bytes_left;
      logic [4:0]           burst_left;
      logic [3:0]           s1;
      logic [3:0]           s2;
      logic [3:0]           s3;
      logic [3:0]           sense;
   } fdcc_state_t;

   fdcc_state_t r;
   fdcc_state_t n;

   logic        step_go;
   logic        hut_go;
   logic        hut_stop;
   logic        hlt_go;
   logic        step_busy;
   logic        hut_done;
   logic        hlt_done;
   logic [31:0] unit_cyc;
   logic [8:0]  srt_units;
   logic [8:0]  hut_units;
   logic [8:0]  hlt_units;
   logic        setup;
   logic        acc_wr;
   logic        acc_rd;
   logic        xfer_evt;
   logic [7:0]  st3;
   logic [4:0]  burst;

   always_comb begin
      case (r.rate)
         fdcc_pkg::RATE_1M:   unit_cyc = 32'(UNIT_CYC * 2);
         fdcc_pkg::RATE_500K: unit_cyc = 32'(UNIT_CYC * 4);
         fdcc_pkg::RATE_300K: unit_cyc = 32'((UNIT_CYC * 20) / 3);
         fdcc_pkg::RATE_250K: unit_cyc = 32'(UNIT_CYC * 8);
         default:             unit_cyc = 32'(UNIT_CYC);
      endcase
   end

   assign srt_units = {4'h0, fdcc_pkg::SRT_BASE - {1'b0, r.step_rate_time}};
   assign hut_units = (r.head_unload_time == 4'h0) ? fdcc_pkg::TIME_CODE0 : {1'b0, r.head_unload_time, 4'h0};
   assign hlt_units = (r.head_load_time == 7'h00) ? fdcc_pkg::TIME_CODE0 : {1'b0, r.head_load_time, 1'b0};

   assign st3   = {1'b0, r.sense[1], r.sense[2], r.sense[0], r.sense[3], 3'h0};
   // Single byte bursts with FIFO off
   assign burst = r.fifo_off_bit ? 5'h01 : {1'b0, r.thr} + 5'h01;

   assign setup  = PSEL & ~PENABLE & ~r.pready;
   assign acc_wr = PSEL & PENABLE & r.pready & PWRITE;
   assign acc_rd = PSEL & PENABLE & r.pready & ~PWRITE;
   // Byte taken by DMA ack or data access
   assign xfer_evt = r.nd ? (r.host_transfer_ready_bit & (acc_wr | acc_rd) & (PADDR == fdcc_pkg::OFS_DATA))
                          : (r.drq & XFER_ACK);

   always_comb begin
      n        = r;
      step_go  = 1'b0;
      hut_go   = 1'b0;
      hut_stop = 1'b0;
      hlt_go   = 1'b0;
      n.step   = 1'b0;
      // Pins pass three flops; a level counts once stages two and three agree
      n.s1 = {TWO_SIDE, READY_IN, WPROT, TRK0};
      n.s2 = r.s1;
      n.s3 = r.s2;
      for (int i = 0; i < 4; i++) begin
         if (r.s2[i] == r.s3[i]) begin
            n.sense[i] = r.s3[i];
         end
      end

      // Read data prepared in setup, answered in access
      n.pready = setup;
      if (setup) begin
         n.pslverr = 1'b0;
         n.prdata  = 32'h0000_0000;
         case (PADDR)
            fdcc_pkg::OFS_CMD:     n.prdata = 32'h0000_0000;
            fdcc_pkg::OFS_SPECIFY: n.prdata = {15'h0000, r.nd, 1'b0, r.head_load_time, r.head_unload_time, r.step_rate_time};
            fdcc_pkg::OFS_CONFIG:  n.prdata = {16'h0000, r.precomp_start_track, r.thr, 1'b0, r.poll_dis, r.fifo_off_bit, r.auto_seek_enable};
            fdcc_pkg::OFS_SEEKARG: n.prdata = {15'h0000, r.reldir, r.relcnt, r.target};
            fdcc_pkg::OFS_STATUS:  n.prdata = {16'h0000, r.st0, 1'b0, ~r.nd, r.head, r.res_valid,
                                              (r.phase != fdcc_pkg::FDCC_P_IDLE), r.busy, r.host_transfer_ready_bit, r.intr};
            fdcc_pkg::OFS_RESULT:  n.prdata = {16'h0000, r.res1, r.res0};
            fdcc_pkg::OFS_DATA:    n.prdata = 32'h0000_0000;
            fdcc_pkg::OFS_RATE:    n.prdata = {29'h0000_0000, r.rate};
            fdcc_pkg::OFS_CYL:     n.prdata = {24'h00_0000, r.present_cylinder};
            default:               n.pslverr = 1'b1;
         endcase
      end

      // Register writes steer the engine directly
      if (acc_wr) begin
         case (PADDR)
            fdcc_pkg::OFS_SPECIFY: begin
               n.step_rate_time = PWDATA[3:0];
               n.head_unload_time = PWDATA[7:4];
               n.head_load_time = PWDATA[14:8];
               n.nd  = PWDATA[16];
            end
            fdcc_pkg::OFS_CONFIG: begin
               n.auto_seek_enable      = PWDATA[0];
               n.fifo_off_bit    = PWDATA[1];
               n.poll_dis = PWDATA[2];
               n.thr      = PWDATA[7:4];
               n.precomp_start_track   = PWDATA[15:8];
            end
            fdcc_pkg::OFS_SEEKARG: begin
               n.target = PWDATA[7:0];
               n.relcnt = PWDATA[15:8];
               n.reldir = PWDATA[16];
            end
            fdcc_pkg::OFS_RATE: n.rate = PWDATA[2:0];
            default: ;
         endcase
      end
      if (acc_rd && (PADDR == fdcc_pkg::OFS_RESULT)) begin
         n.res_valid = 1'b0;
      end

      // Command dispatch; events below may override, so a set wins a clear
      if (acc_wr && (PADDR == fdcc_pkg::OFS_CMD)) begin
         case (PWDATA[3:0])
            fdcc_pkg::OP_SENSE_INT: begin
               n.intr      = 1'b0;
               n.busy      = 1'b0;
               n.res0      = r.intr ? {r.st0[7:3], 1'b0, r.st0[1:0]} : {fdcc_pkg::IC_INVALID, 6'h00};
               n.res1      = r.present_cylinder;
               n.res_valid = 1'b1;
            end
            fdcc_pkg::OP_SENSE_DRV: begin
               n.res0      = st3;
               n.res1      = 8'h00;
               n.res_valid = 1'b1;
            end
            fdcc_pkg::OP_VERSION: begin
               n.res0      = VERSION_ID;
               n.res1      = 8'h00;
               n.res_valid = 1'b1;
            end
            fdcc_pkg::OP_SEEK, fdcc_pkg::OP_REL_SEEK, fdcc_pkg::OP_RECAL: begin
               if (r.phase == fdcc_pkg::FDCC_P_IDLE && !r.busy) begin
                  n.phase      = fdcc_pkg::FDCC_P_SEEK;
                  n.busy       = 1'b1;
                  n.steps_left = r.relcnt;
                  n.recal_cnt  = 7'h00;
                  if (PWDATA[3:0] == fdcc_pkg::OP_SEEK) begin
                     n.smode = fdcc_pkg::FDCC_M_SEEK;
                  end else if (PWDATA[3:0] == fdcc_pkg::OP_REL_SEEK) begin
                     n.smode = fdcc_pkg::FDCC_M_REL;
                  end else begin
                     n.smode = fdcc_pkg::FDCC_M_RECAL;
                     n.present_cylinder   = 8'h00;
                  end
               end
            end
            fdcc_pkg::OP_XFER: begin
               if (r.phase == fdcc_pkg::FDCC_P_IDLE && !r.busy) begin
                  n.bytes_left = PWDATA[15:8];
                  n.wr_dir     = PWDATA[16];
                  n.burst_left = 5'h00;
                  hut_stop     = 1'b1;
                  if (r.auto_seek_enable && (r.target != r.present_cylinder)) begin
                     n.phase = fdcc_pkg::FDCC_P_SEEK;
                     n.smode = fdcc_pkg::FDCC_M_IMPL;
                  end else begin
                     n.phase = fdcc_pkg::FDCC_P_HLOAD;
                  end
               end
            end
            default: ;
         endcase
      end

      case (r.phase)
         fdcc_pkg::FDCC_P_IDLE: ;
         fdcc_pkg::FDCC_P_SEEK: begin
            // First step leaves at once, so the first interval is shorter
            if (!step_busy && !r.step) begin
               case (r.smode)
                  fdcc_pkg::FDCC_M_REL: begin
                     if (r.steps_left == 8'h00) begin
                        n.phase = fdcc_pkg::FDCC_P_IDLE;
                        n.intr  = 1'b1;
                        n.st0   = {fdcc_pkg::IC_NORMAL, 6'h20};
                     end else if (!r.reldir && r.sense[0]) begin
                        n.phase = fdcc_pkg::FDCC_P_IDLE;
                        n.intr  = 1'b1;
                        n.st0   = {fdcc_pkg::IC_ABNORMAL, 6'h30};
                     end else begin
                        n.dir        = r.reldir;
                        n.step       = 1'b1;
                        step_go      = 1'b1;
                        n.steps_left = r.steps_left - 8'h01;
                        n.present_cylinder        = r.reldir ? r.present_cylinder + 8'h01 : r.present_cylinder - 8'h01;
                     end
                  end
                  fdcc_pkg::FDCC_M_RECAL: begin
                     if (r.sense[0]) begin
                        n.phase = fdcc_pkg::FDCC_P_IDLE;
                        n.intr  = 1'b1;
                        n.st0   = {fdcc_pkg::IC_NORMAL, 6'h20};
                     end else if (r.recal_cnt == fdcc_pkg::RECAL_MAX) begin
                        n.phase = fdcc_pkg::FDCC_P_IDLE;
                        n.intr  = 1'b1;
                        n.st0   = {fdcc_pkg::IC_ABNORMAL, 6'h30};
                     end else begin
                        n.dir       = 1'b0;
                        n.step      = 1'b1;
                        step_go     = 1'b1;
                        n.recal_cnt = r.recal_cnt + 7'h01;
                     end
                  end
                  default: begin
                     if (r.present_cylinder == r.target) begin
                        if (r.smode == fdcc_pkg::FDCC_M_IMPL) begin
                           n.phase = fdcc_pkg::FDCC_P_HLOAD;
                        end else begin
                           n.phase = fdcc_pkg::FDCC_P_IDLE;
                           n.intr  = 1'b1;
                           n.st0   = {fdcc_pkg::IC_NORMAL, 6'h20};
                        end
                     end else begin
                        n.dir   = (r.present_cylinder < r.target);
                        n.step  = 1'b1;
                        step_go = 1'b1;
                        n.present_cylinder   = (r.present_cylinder < r.target) ? r.present_cylinder + 8'h01 : r.present_cylinder - 8'h01;
                     end
                  end
               endcase
            end
         end
         fdcc_pkg::FDCC_P_HLOAD: begin
            if (!r.head) begin
               n.head  = 1'b1;
               hlt_go  = 1'b1;
               n.phase = fdcc_pkg::FDCC_P_HWAIT;
            end else begin
               n.phase = fdcc_pkg::FDCC_P_XFER;
            end
         end
         fdcc_pkg::FDCC_P_HWAIT: begin
            if (hlt_done) begin
               n.phase = fdcc_pkg::FDCC_P_XFER;
            end
         end
         fdcc_pkg::FDCC_P_XFER: begin
            if (r.bytes_left == 8'h00) begin
               n.phase     = fdcc_pkg::FDCC_P_IDLE;
               n.intr      = 1'b1;
               n.st0       = {fdcc_pkg::IC_NORMAL, 6'h00};
               n.res0      = {fdcc_pkg::IC_NORMAL, 6'h00};
               n.res1      = r.present_cylinder;
               n.res_valid = 1'b1;
               hut_go      = 1'b1;
            end else if (r.burst_left == 5'h00) begin
               n.burst_left = burst;
               if (r.nd) begin
                  n.host_transfer_ready_bit  = 1'b1;
                  n.intr = 1'b1;
               end else begin
                  n.drq = 1'b1;
               end
            end else if (xfer_evt) begin
               n.bytes_left = r.bytes_left - 8'h01;
               n.burst_left = r.burst_left - 5'h01;
               if (r.burst_left == 5'h01 || r.bytes_left == 8'h01) begin
                  n.burst_left = 5'h00;
                  n.drq        = 1'b0;
                  n.host_transfer_ready_bit        = 1'b0;
                  n.intr       = 1'b0;
               end
            end
         end
         default: n.phase = fdcc_pkg::FDCC_P_IDLE;
      endcase

      if (hut_done) begin
         n.head = 1'b0;
      end

      if (!r.poll_done && !r.poll_dis && !r.head && !r.intr && r.phase == fdcc_pkg::FDCC_P_IDLE) begin
         n.poll_done = 1'b1;
         n.intr      = 1'b1;
         n.st0       = {fdcc_pkg::IC_POLL, 6'h00};
      end

      n.precomp = (r.phase == fdcc_pkg::FDCC_P_XFER) && r.wr_dir && (r.present_cylinder >= r.precomp_start_track);
   end

   always_ff @(posedge CLK) begin
      if (!RST_N) begin
         r          <= '0;
         r.step_rate_time      <= fdcc_pkg::RST_SRT;
         r.head_unload_time      <= fdcc_pkg::RST_HUT;
         r.head_load_time      <= fdcc_pkg::RST_HLT;
         r.auto_seek_enable      <= fdcc_pkg::RST_EIS;
         r.fifo_off_bit    <= fdcc_pkg::RST_FIFO_OFF_BIT;
         r.poll_dis <= fdcc_pkg::RST_POLLDIS;
         r.thr      <= fdcc_pkg::RST_THR;
         r.precomp_start_track   <= fdcc_pkg::RST_PRECOMP_START_TRACK;
         r.rate     <= fdcc_pkg::RST_RATE;
         r.phase    <= fdcc_pkg::FDCC_P_IDLE;
         r.smode    <= fdcc_pkg::FDCC_M_SEEK;
      end else begin
         r <= n;
      end
   end

   fdcc_timer #(.UW(9), .CW(32)) u_step (
      .clk      (CLK),
      .rst_n    (RST_N),
      .start    (step_go),
      .stop     (1'b0),
      .units    (srt_units),
      .unit_cyc (unit_cyc),
      .busy     (step_busy),
      .done     ()
   );

   fdcc_timer #(.UW(9), .CW(32)) u_hut (
      .clk      (CLK),
      .rst_n    (RST_N),
      .start    (hut_go),
      .stop     (hut_stop),
      .units    (hut_units),
      .unit_cyc (unit_cyc),
      .busy     (),
      .done     (hut_done)
   );

   fdcc_timer #(.UW(9), .CW(32)) u_hlt (
      .clk      (CLK),
      .rst_n    (RST_N),
      .start    (hlt_go),
      .stop     (1'b0),
      .units    (hlt_units),
      .unit_cyc (unit_cyc),
      .busy     (),
      .done     (hlt_done)
   );

   assign PRDATA    = r.prdata;
   assign PREADY    = r.pready;
   assign PSLVERR   = r.pslverr;
   assign INT       = r.intr;
   assign DRQ       = r.drq;
   assign STEP      = r.step;
   assign DIR       = r.dir;
   assign HEAD_LOAD = r.head;
   assign PRECOMP   = r.precomp;

endmodule // fdcc_top
`default_nettype wire

// ==== bench/fdcc_drive.sv ====
`timescale 1ns/1ps
`default_nettype none
module fdcc_drive (
   // Stepper in
   input  wire logic clk,
   input  wire logic step,
   input  wire logic dir,
   // Sense out
   output wire logic trk0
);
   int pos = 0;
   always @(posedge clk) begin
      if (step && dir) pos <= pos + 1;
      else if (step && pos > 0) pos <= pos - 1;
   end
   // Hard stop at track 0 only
   assign trk0 = (pos == 0);
endmodule // fdcc_drive
`default_nettype wire

// ==== bench/fdcc_chk.sv ====
`timescale 1ns/1ps
`default_nettype none
module fdcc_chk #(
   parameter int UNIT_CYC = 4
) (
   // Clock and reset
   input wire logic        CLK,
   input wire logic        RST_N,
   // APB
   input wire logic        PSEL,
   input wire logic        PENABLE,
   input wire logic        PWRITE,
   input wire logic [7:0]  PADDR,
   input wire logic [31:0] PWDATA,
   input wire logic [31:0] PRDATA,
   input wire logic        PREADY,
   input wire logic        PSLVERR,
   // Host and drive
   input wire logic        INT,
   input wire logic        DRQ,
   input wire logic        STEP,
   input wire logic        HEAD_LOAD,
   input wire logic        PRECOMP
);
   default clocking cb @(posedge CLK); endclocking
   default disable iff (!RST_N);
   wire sns = PSEL && PENABLE && PREADY && PWRITE && PADDR == 8'h00 && PWDATA[3:0] == 4'h4;
   a_apb_ready: assert property (PSEL && !PENABLE |=> PREADY ##1 !PREADY) else $error("ready");
   a_apb_unmapped: assert property (PSEL && !PENABLE && PADDR > 8'h20 |=> PSLVERR && PRDATA == 32'h0)
      else $error("unmapped");
   a_sense_clear: assert property (sns |-> ##[1:2] !INT)
      else $error("int kept");
   a_step_gap: assert property (STEP |=> !STEP [*3])
      else $error("step gap");
   a_poll_once: assert property ($rose(RST_N) |-> ##[0:4] INT)
      else $error("no poll int");
   a_reset_idle: assert property ($rose(RST_N) |-> !STEP && !DRQ && !HEAD_LOAD && !PRECOMP)
      else $error("reset outputs");
   a_drq_loaded: assert property (DRQ |-> HEAD_LOAD)
      else $error("drq unloaded");
   a_precomp_head: assert property (PRECOMP |-> HEAD_LOAD)
      else $error("precomp unloaded");
   c_step: cover property (STEP);
   c_drq: cover property (DRQ);
   c_precomp: cover property (PRECOMP);
endmodule // fdcc_chk
bind fdcc_top fdcc_chk #(.UNIT_CYC(UNIT_CYC)) u_chk (.CLK(CLK), .RST_N(RST_N), .PSEL(PSEL), .PENABLE(PENABLE),
   .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
   .INT(INT), .DRQ(DRQ), .STEP(STEP), .HEAD_LOAD(HEAD_LOAD), .PRECOMP(PRECOMP));
`default_nettype wire

// ==== bench/test_fdcc_top.sv ====
`timescale 1ns/1ps
`default_nettype none
module test_fdcc_top;
   logic        CLK = 0, RST_N = 0, PSEL = 0, PENABLE = 0, PWRITE = 0, XFER_ACK = 0, WPROT = 0;
   logic [7:0]  PADDR = 8'h00;
   logic [31:0] PWDATA = 32'h0, PRDATA, rd;
   logic        PREADY, PSLVERR, INT, DRQ, STEP, DIR, HEAD_LOAD, PRECOMP, TRK0;
   int          n_fail = 0, total_checks = 0, n_ack = 0;
   // Version code arbitrary
   fdcc_top #(.UNIT_CYC(4), .VERSION_ID(8'h3C)) dut (.CLK(CLK), .RST_N(RST_N), .PSEL(PSEL), .PENABLE(PENABLE),
      .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
      .TRK0(TRK0), .WPROT(WPROT), .READY_IN(1'b1), .TWO_SIDE(1'b1), .XFER_ACK(XFER_ACK), .INT(INT), .DRQ(DRQ),
      .STEP(STEP), .DIR(DIR), .HEAD_LOAD(HEAD_LOAD), .PRECOMP(PRECOMP));
   fdcc_drive mech (.clk(CLK), .step(STEP), .dir(DIR), .trk0(TRK0));
   initial forever #12.5 CLK = ~CLK;
   // Ack lags request; counts only overlap, as the engine does
   always @(posedge CLK) begin
      XFER_ACK <= DRQ;
      if (XFER_ACK && DRQ) n_ack <= n_ack + 1;
   end
   task report_and_stop;
      $display("checks %0d mismatches %0d", total_checks, n_fail);
      if (n_fail == 0 && total_checks > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      total_checks++;
      if (g !== e) begin
         n_fail++;
         $display("mismatch %s expected %h seen %h", nm, e, g);
      end
   endtask
   task acc(input logic w, input logic [7:0] a, input logic [31:0] d);
      int i;
      @(posedge CLK);
      PSEL <= 1'b1;
      PWRITE <= w;
      PADDR <= a;
      PWDATA <= d;
      @(posedge CLK);
      PENABLE <= 1'b1;
      i = 0;
      do begin
         @(posedge CLK);
         i++;
      end while (PREADY !== 1'b1 && i < 20);
      rd = PRDATA;
      PSEL <= 1'b0;
      PENABLE <= 1'b0;
      if (PREADY !== 1'b1) begin
         n_fail++;
         report_and_stop;
      end
   endtask
   task wint;
      int i;
      for (i = 0; i < 20000 && INT !== 1'b1; i++) @(posedge CLK);
      if (INT !== 1'b1) begin
         n_fail++;
         report_and_stop;
      end
   endtask
   task res(input string nm, input logic [31:0] e);
      acc(1'b0, 8'h14, 32'h0);
      chk(nm, e, rd & 32'hFF);
   endtask
   task op(input logic [31:0] c, input logic [31:0] e);
      acc(1'b1, 8'h00, c);
      wint;
      acc(1'b1, 8'h00, 32'h4);
      res("sense status", e);
   endtask
   initial begin
      repeat (5) @(posedge CLK);
      RST_N <= 1'b1;
      op(32'h0, 32'hC0);
      acc(1'b0, 8'h08, 32'h0);
      chk("config", 32'h2, rd);
      acc(1'b0, 8'h80, 32'h0);
      acc(1'b1, 8'h00, 32'h6);
      res("version", 32'h3C);
      acc(1'b1, 8'h1C, 32'h0);
      acc(1'b1, 8'h04, 32'h0108);
      acc(1'b1, 8'h0C, 32'h3);
      acc(1'b1, 8'h00, 32'h1);
      wint;
      acc(1'b0, 8'h10, 32'h0);
      chk("busy", 32'h2044, rd & 32'hFF44);
      acc(1'b1, 8'h00, 32'h4);
      res("seek status", 32'h20);
      acc(1'b0, 8'h20, 32'h0);
      chk("seek cyl", 32'h3, rd);
      acc(1'b1, 8'h0C, 32'h0500);
      op(32'h2, 32'h70);
      chk("dir out", 32'h0, DIR);
      op(32'h3, 32'h20);
      acc(1'b1, 8'h00, 32'h5);
      res("drive status", 32'h38);
      acc(1'b1, 8'h0C, 32'h1FF00);
      acc(1'b1, 8'h00, 32'h2);
      op(32'h2, 32'h20);
      acc(1'b0, 8'h20, 32'h0);
      chk("rel cyl", 32'hFF, rd);
      acc(1'b1, 8'h0C, 32'h10300);
      op(32'h2, 32'h20);
      acc(1'b0, 8'h20, 32'h0);
      chk("wrap cyl", 32'h2, rd);
      acc(1'b1, 8'h00, 32'h10207);
      wint;
      res("xfer status", 32'h0);
      chk("acks", 32'h2, n_ack);
      repeat (1000) @(posedge CLK);
      chk("head held", 32'h1, HEAD_LOAD);
      repeat (40) @(posedge CLK);
      chk("head unload", 32'h0, HEAD_LOAD);
      acc(1'b1, 8'h00, 32'h4);
      res("xfer sense", 32'h0);
      acc(1'b1, 8'h04, 32'h10108);
      acc(1'b0, 8'h10, 32'h0);
      chk("dma mode", 32'h0, rd & 32'h40);
      // Non-DMA write, implied seek, two byte burst
      acc(1'b1, 8'h08, 32'h0311);
      acc(1'b1, 8'h0C, 32'h3);
      acc(1'b1, 8'h00, 32'h10207);
      wint;
      chk("precomp", 32'h1, PRECOMP);
      chk("dir in", 32'h1, DIR);
      acc(1'b0, 8'h10, 32'h0);
      chk("host ready", 32'h3, rd & 32'h3);
      acc(1'b0, 8'h20, 32'h0);
      chk("implied cyl", 32'h3, rd);
      acc(1'b1, 8'h18, 32'h0);
      acc(1'b0, 8'h10, 32'h0);
      chk("burst", 32'h3, rd & 32'h3);
      acc(1'b1, 8'h18, 32'h0);
      acc(1'b0, 8'h10, 32'h0);
      chk("nondma end", 32'h11, rd & 32'h1F);
      // Pin passes the synchroniser before the command
      WPROT <= 1'b1;
      repeat (5) @(posedge CLK);
      acc(1'b1, 8'h00, 32'h5);
      res("drive prot", 32'h68);
      report_and_stop;
   end
endmodule // test_fdcc_top
`default_nettype wire
